//--- shared/toc_pkg.sv
/*
  constants, register map and field layouts for the timer compare block.
  assumes a 32-bit AHB-Lite bus, byte addresses decoded on haddr[7:0].
*/
// Function
// - counter equal to compare value sets its flag and drives its pin level
// - compare pin latches sit low during reset
// - compare match interrupts only with compare enable set and cpu mask clear
// - flag clears after a flags read that saw it, then low byte access
// - writing the high byte halts that compare until its low byte is written
// - pin enable clear leaves pin free, interrupt still possible
// - divide-by-2 acts at equality; other clocks act one count later
// - forced bit copies the level to the enabled pin, no flag, no interrupt
// - forced bits do nothing in single-pulse or modulation mode
// - single-pulse mode uses capture one and compare one for pin one
// - trigger loads counter fffc, pin one level two, capture fffd, flag
// - single-pulse compare one match drives level one, ending the pulse
// - single-pulse trigger flag interrupts when capture enable is set
// - single-pulse never sets compare flag one; compare flag two still works
// - single-pulse compare two gives flag only, never a pin waveform
// - both mode bits set means modulation mode only
// - special modes stop capture one; capture two still works
// - modulation compare two match reloads the counter with fffc
// - modulation: compare one gives level one, compare two level two
// - modulation mode never sets either compare flag
// - modulation compare two sets capture flag one, may interrupt
// - both compare values reset to 8000
// - clock select picks cpu/2, cpu/4, cpu/8 or external clock
package toc_pkg;

  localparam logic [7:0] A_CTRL_A  = 8'h00;
  localparam logic [7:0] A_CTRL_B  = 8'h04;
  localparam logic [7:0] A_FLAGS   = 8'h08;
  localparam logic [7:0] A_MASK    = 8'h0c;
  localparam logic [7:0] A_CNT     = 8'h10;
  localparam logic [7:0] A_CMP_HI [2] = '{8'h20, 8'h28};
  localparam logic [7:0] A_CMP_LO [2] = '{8'h24, 8'h2c};
  localparam logic [7:0] A_CAP_HI [2] = '{8'h30, 8'h38};
  localparam logic [7:0] A_CAP_LO [2] = '{8'h34, 8'h3c};

  localparam logic [15:0] CMP_RESET = 16'h8000;
  localparam logic [15:0] CNT_LOAD  = 16'hfffc;
  localparam logic [15:0] CAP_PULSE = 16'hfffd;

  localparam logic [1:0] CLK_DIV4 = 2'h0;
  localparam logic [1:0] CLK_DIV2 = 2'h1;
  localparam logic [1:0] CLK_DIV8 = 2'h2;
  localparam logic [1:0] CLK_EXT  = 2'h3;
  localparam logic [2:0] DIV2_LAST = 3'h1;
  localparam logic [2:0] DIV4_LAST = 3'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;

  typedef struct packed {
    logic capture_irq_enable;
    logic compare_irq_enable;
    logic overflow_irq_enable;
    logic forced_output_two;
    logic forced_output_one;
    logic compare_output_level_two;
    logic capture_edge_one;
    logic compare_output_level_one;
  } toc_ctrl_a_t;

  typedef struct packed {
    logic       compare_pin_enable_one;
    logic       compare_pin_enable_two;
    logic       single_pulse_select;
    logic       pwm_select;
    logic [1:0] timer_clock_select;
    logic       capture_edge_two;
    logic       ext_edge_rising;
  } toc_ctrl_b_t;

  // flags register: {capture flags [3:2], compare match flags [1:0]}
  typedef struct packed {
    logic [1:0] capture_flag;
    logic [1:0] compare_match_flag;
  } toc_flags_t;

endpackage : toc_pkg

//--- design/toc_tick.sv
/*
  timer tick generator: prescaler of the cpu clock or external edge detect.
  assumes ext_clk is already synchronous to hclk.
*/
`timescale 1ns/10ps
module toc_tick
  import toc_pkg::*;
(
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic [1:0] clk_sel,
  input  wire logic       ext_edge_rising,
  input  wire logic       ext_clk,
  output logic            tick
);
  logic [2:0] div_reg;
  logic [2:0] last;
  logic       ext_prev_reg;
  logic       ext_edge;

  always_comb begin
    unique case (clk_sel)
      CLK_DIV2: last = DIV2_LAST;
      CLK_DIV4: last = DIV4_LAST;
      CLK_DIV8: last = DIV8_LAST;
      CLK_EXT:  last = DIV8_LAST;
    endcase
  end

  assign ext_edge = ext_edge_rising ? (ext_clk & ~ext_prev_reg)
                                    : (~ext_clk & ext_prev_reg);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_reg <= 3'h0;
    end else if (div_reg >= last) begin
      div_reg <= 3'h0;
    end else begin
      div_reg <= div_reg + 3'h1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_prev_reg <= 1'b0;
      tick         <= 1'b0;
    end else begin
      ext_prev_reg <= ext_clk;
      tick         <= (clk_sel == CLK_EXT) ? ext_edge : (div_reg >= last);
    end
  end
endmodule : toc_tick

//--- design/toc_timer_compare.sv
/*
  16-bit timer with output compare, forced output, single-pulse and
  modulation modes, input capture and a zero-wait AHB-Lite register slave.
  assumes a single AHB-Lite master; capture inputs synchronous to hclk.
*/
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/10ps
module toc_timer_compare
  import toc_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        capture_input_one,
  input  wire logic        capture_input_two,
  input  wire logic        ext_clk,
  output logic [1:0]       compare_output_pin,
  output logic [1:0]       compare_pin_oe_n,
  output logic             timer_irq
);
  toc_ctrl_a_t ctrl_a_reg;
  toc_ctrl_b_t ctrl_b_reg;
  toc_flags_t  flags;
  logic        cpu_mask_reg;
  logic [15:0] cmp_reg [2];
  logic [15:0] cap_reg [2];
  logic [15:0] cnt_reg;
  logic [1:0]  inhibit_reg;
  logic [1:0]  cmp_flag_reg;
  logic [1:0]  cap_flag_reg;
  logic [1:0]  cmp_arm_reg;
  logic [1:0]  cap_arm_reg;
  logic [1:0]  pend_reg;
  logic [1:0]  eq;
  logic [1:0]  hit;
  logic [1:0]  cmp_set;
  logic [1:0]  cap_set;
  logic        tick;
  logic        tick_d_reg;
  logic        cap1_prev_reg;
  logic        cap2_prev_reg;
  logic        cap1_edge;
  logic        cap2_edge;
  logic        pwm_mode;
  logic        opm_mode;
  logic        special;
  logic        fast;
  logic        opm_trig;
  logic        addr_ok;
  logic        rd_ph;
  logic        dp_write_reg;
  logic [7:0]  dp_addr_reg;
  logic        cnt_wr;
  logic [31:0] rdata_next;

  // bus slave: zero wait, reads answered from a flop in the data phase
  assign addr_ok = hsel & htrans[1] & hready;
  assign rd_ph   = addr_ok & ~hwrite;
  assign cnt_wr  = dp_write_reg && (dp_addr_reg == A_CNT);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write_reg <= 1'b0;
      dp_addr_reg  <= 8'h00;
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end else begin
      dp_write_reg <= addr_ok & hwrite;
      dp_addr_reg  <= haddr[7:0];
      hreadyout    <= 1'b1;
      hresp        <= 1'b0;
    end
  end

  assign flags = '{capture_flag: cap_flag_reg,
                   compare_match_flag: cmp_flag_reg};

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (haddr[7:0])
      A_CTRL_A:    rdata_next[7:0]  = ctrl_a_reg;
      A_CTRL_B:    rdata_next[7:0]  = ctrl_b_reg;
      A_FLAGS:     rdata_next[3:0]  = flags;
      A_MASK:      rdata_next[0]    = cpu_mask_reg;
      A_CNT:       rdata_next[15:0] = cnt_reg;
      A_CMP_HI[0]: rdata_next[7:0]  = cmp_reg[0][15:8];
      A_CMP_LO[0]: rdata_next[7:0]  = cmp_reg[0][7:0];
      A_CMP_HI[1]: rdata_next[7:0]  = cmp_reg[1][15:8];
      A_CMP_LO[1]: rdata_next[7:0]  = cmp_reg[1][7:0];
      A_CAP_HI[0]: rdata_next[7:0]  = cap_reg[0][15:8];
      A_CAP_LO[0]: rdata_next[7:0]  = cap_reg[0][7:0];
      A_CAP_HI[1]: rdata_next[7:0]  = cap_reg[1][15:8];
      A_CAP_LO[1]: rdata_next[7:0]  = cap_reg[1][7:0];
      default:     rdata_next       = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_ph) begin
      hrdata <= rdata_next;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_a_reg   <= '0;
      ctrl_b_reg   <= '0;
      cpu_mask_reg <= 1'b1;
    end else if (dp_write_reg) begin
      if (dp_addr_reg == A_CTRL_A) ctrl_a_reg <= hwdata[7:0];
      if (dp_addr_reg == A_CTRL_B) ctrl_b_reg <= hwdata[7:0];
      if (dp_addr_reg == A_MASK) cpu_mask_reg <= hwdata[0];
    end
  end

  // modes and timebase
  assign pwm_mode = ctrl_b_reg.pwm_select;
  assign opm_mode = ctrl_b_reg.single_pulse_select & ~pwm_mode;
  assign special  = pwm_mode | opm_mode;
  assign fast     = ctrl_b_reg.timer_clock_select == CLK_DIV2;

  toc_tick u_tick (
    .hclk            (hclk),
    .hresetn         (hresetn),
    .clk_sel         (ctrl_b_reg.timer_clock_select),
    .ext_edge_rising (ctrl_b_reg.ext_edge_rising),
    .ext_clk         (ext_clk),
    .tick            (tick)
  );

  assign cap1_edge = ctrl_a_reg.capture_edge_one
                   ? (capture_input_one & ~cap1_prev_reg)
                   : (~capture_input_one & cap1_prev_reg);
  assign cap2_edge = ctrl_b_reg.capture_edge_two
                   ? (capture_input_two & ~cap2_prev_reg)
                   : (~capture_input_two & cap2_prev_reg);
  assign opm_trig  = opm_mode & cap1_edge;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_d_reg    <= 1'b0;
      cap1_prev_reg <= 1'b0;
      cap2_prev_reg <= 1'b0;
    end else begin
      tick_d_reg    <= tick;
      cap1_prev_reg <= capture_input_one;
      cap2_prev_reg <= capture_input_two;
    end
  end

  // free-running counter; reload wins over counting
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg <= CNT_LOAD;
    end else if (cnt_wr || opm_trig) begin
      cnt_reg <= CNT_LOAD;
    end else if (pwm_mode && hit[1]) begin
      cnt_reg <= CNT_LOAD;
    end else if (tick) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // per-channel compare, flag and capture logic
  for (genvar i = 0; i < 2; i++) begin : g_ch
    // the counter settles one cycle after its tick, so compare then
    assign eq[i] = tick_d_reg & ~inhibit_reg[i] & (cnt_reg == cmp_reg[i]);
    // slower clocks act at the next count: hold the match one tick
    assign hit[i] = fast ? eq[i] : (tick_d_reg & pend_reg[i]);

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        pend_reg[i] <= 1'b0;
      end else if (tick_d_reg) begin
        pend_reg[i] <= eq[i] & ~fast;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cmp_reg[i]     <= CMP_RESET;
        inhibit_reg[i] <= 1'b0;
      end else if (dp_write_reg && dp_addr_reg == A_CMP_HI[i]) begin
        cmp_reg[i][15:8] <= hwdata[7:0];
        inhibit_reg[i]   <= 1'b1;
      end else if (dp_write_reg && dp_addr_reg == A_CMP_LO[i]) begin
        cmp_reg[i][7:0]  <= hwdata[7:0];
        inhibit_reg[i]   <= 1'b0;
      end
    end

    // an arrival in the clearing cycle wins over the clear
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cmp_flag_reg[i] <= 1'b0;
        cmp_arm_reg[i]  <= 1'b0;
      end else if (addr_ok && haddr[7:0] == A_CMP_LO[i] && cmp_arm_reg[i]) begin
        cmp_flag_reg[i] <= cmp_set[i];
        cmp_arm_reg[i]  <= 1'b0;
      end else begin
        cmp_flag_reg[i] <= cmp_flag_reg[i] | cmp_set[i];
        if (rd_ph && haddr[7:0] == A_FLAGS && cmp_flag_reg[i])
          cmp_arm_reg[i] <= 1'b1;
      end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        cap_flag_reg[i] <= 1'b0;
        cap_arm_reg[i]  <= 1'b0;
      end else if (addr_ok && haddr[7:0] == A_CAP_LO[i] && cap_arm_reg[i]) begin
        cap_flag_reg[i] <= cap_set[i];
        cap_arm_reg[i]  <= 1'b0;
      end else begin
        cap_flag_reg[i] <= cap_flag_reg[i] | cap_set[i];
        if (rd_ph && haddr[7:0] == A_FLAGS && cap_flag_reg[i])
          cap_arm_reg[i] <= 1'b1;
      end
    end
  end

  assign cmp_set[0] = hit[0] & ~special;
  assign cmp_set[1] = hit[1] & ~pwm_mode;
  assign cap_set[0] = pwm_mode ? hit[1] : cap1_edge;
  assign cap_set[1] = cap2_edge;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_reg[0] <= 16'h0000;
      cap_reg[1] <= 16'h0000;
    end else begin
      if (opm_trig) begin
        cap_reg[0] <= CAP_PULSE;
      end else if (cap1_edge && !special) begin
        cap_reg[0] <= cnt_reg;
      end
      if (cap2_edge) cap_reg[1] <= cnt_reg;
    end
  end

  // pin one: plain compare, forced, single pulse or modulation
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_output_pin[0] <= 1'b0;
    end else if (ctrl_b_reg.compare_pin_enable_one) begin
      if (pwm_mode) begin
        if (hit[1]) compare_output_pin[0] <= ctrl_a_reg.compare_output_level_two;
        else if (hit[0]) compare_output_pin[0] <= ctrl_a_reg.compare_output_level_one;
      end else if (opm_mode) begin
        if (opm_trig) compare_output_pin[0] <= ctrl_a_reg.compare_output_level_two;
        else if (hit[0]) compare_output_pin[0] <= ctrl_a_reg.compare_output_level_one;
      end else if (hit[0] || ctrl_a_reg.forced_output_one) begin
        compare_output_pin[0] <= ctrl_a_reg.compare_output_level_one;
      end
    end
  end

  // pin two carries no waveform in either special mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_output_pin[1] <= 1'b0;
    end else if (ctrl_b_reg.compare_pin_enable_two && !special) begin
      if (hit[1] || ctrl_a_reg.forced_output_two)
        compare_output_pin[1] <= ctrl_a_reg.compare_output_level_two;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_pin_oe_n <= 2'b11;
      timer_irq        <= 1'b0;
    end else begin
      compare_pin_oe_n <= ~{ctrl_b_reg.compare_pin_enable_two,
                            ctrl_b_reg.compare_pin_enable_one};
      timer_irq <= ~cpu_mask_reg &
                   ((ctrl_a_reg.compare_irq_enable & |cmp_flag_reg) |
                    (ctrl_a_reg.capture_irq_enable & |cap_flag_reg));
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_cmp_flag; hit[0] && !special |=> cmp_flag_reg[0]; endproperty
  a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag missed");
  property p_pin_rst; $rose(hresetn) |-> compare_output_pin == 2'b00; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("pin not low at reset");
  property p_irq;
    cmp_flag_reg[0] && ctrl_a_reg.compare_irq_enable && !cpu_mask_reg
      |=> timer_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("compare irq missing");
  property p_clr; $fell(cmp_flag_reg[0]) |-> $past(cmp_arm_reg[0]); endproperty
  a_clr: assert property (p_clr) else $error("flag cleared unarmed");
  property p_inh;
    dp_write_reg && dp_addr_reg == A_CMP_HI[0] |=> inhibit_reg[0] ##0 !eq[0];
  endproperty
  a_inh: assert property (p_inh) else $error("compare not inhibited");
  property p_pin_off;
    !ctrl_b_reg.compare_pin_enable_one |=> $stable(compare_output_pin[0]);
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("disabled pin moved");
  property p_slow;
    $rose(cmp_flag_reg[0]) && !$past(fast) |-> $past(pend_reg[0]);
  endproperty
  a_slow: assert property (p_slow) else $error("slow match too early");
  property p_force;
    ctrl_a_reg.forced_output_one && ctrl_b_reg.compare_pin_enable_one
      && !special && !hit[0]
      |=> compare_output_pin[0] == $past(ctrl_a_reg.compare_output_level_one)
          && !$rose(cmp_flag_reg[0]);
  endproperty
  a_force: assert property (p_force) else $error("forced output wrong");
  property p_trig;
    opm_trig && !cnt_wr |=> cnt_reg == CNT_LOAD && cap_reg[0] == CAP_PULSE
      && cap_flag_reg[0];
  endproperty
  a_trig: assert property (p_trig) else $error("pulse trigger wrong");
  property p_pwm_reload;
    pwm_mode && hit[1] && !cnt_wr |=> cnt_reg == CNT_LOAD && cap_flag_reg[0];
  endproperty
  a_pwm_reload: assert property (p_pwm_reload) else $error("period reload");
  property p_pwm_noflag; pwm_mode |=> !$rose(|cmp_flag_reg); endproperty
  a_pwm_noflag: assert property (p_pwm_noflag) else $error("pwm set flag");

  c_opm: cover property (opm_trig ##[1:300] hit[0]);
  c_pwm: cover property (pwm_mode && hit[1]);
  c_clear: cover property ($fell(cmp_flag_reg[1]));
  c_irq: cover property ($rose(timer_irq));
endmodule : toc_timer_compare

//--- dv/tb_top.sv
/*
  self-checking bench for the timer compare block: AHB-Lite read and write
  tasks and directed sequences for compare, forced output, single-pulse and
  modulation modes.
  assumes toc_pkg and the design files are compiled before it.
*/
`timescale 1ns/10ps
module tb_top
  import toc_pkg::*;
;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        cap_one;
  logic        cap_two;
  logic        ext_clk;
  logic [2:0]  ext_div = 3'h0;
  logic [1:0]  pin;
  logic [1:0]  pin_oe_n;
  logic        timer_irq;
  logic [31:0] q;
  int          n_fail;
  int          total_checks;
  logic [1:0]  sels [4] = '{CLK_DIV2, CLK_DIV4, CLK_DIV8, CLK_EXT};

  always #2.5 hclk = ~hclk;

  // external timer clock: one active edge per 16 cpu cycles, well apart
  always @(posedge hclk) begin
    ext_div <= ext_div + 3'h1;
    if (ext_div == 3'h7) begin
      ext_clk <= ~ext_clk;
    end
  end

  toc_timer_compare DUT (
    .hclk              (hclk),
    .hresetn           (hresetn),
    .hsel              (hsel),
    .haddr             (haddr),
    .htrans            (htrans),
    .hwrite            (hwrite),
    .hsize             (hsize),
    .hwdata            (hwdata),
    .hready            (hreadyout),
    .hreadyout         (hreadyout),
    .hresp             (hresp),
    .hrdata            (hrdata),
    .capture_input_one (cap_one),
    .capture_input_two (cap_two),
    .ext_clk           (ext_clk),
    .compare_output_pin(pin),
    .compare_pin_oe_n  (pin_oe_n),
    .timer_irq         (timer_irq)
  );

  task automatic complete_run;
    if (n_fail == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got,
               exp);
    end
  endtask : chk

  task automatic give_up(input string what);
    n_fail++;
    $display("wrong value at %0t: %s timed out", $time, what);
    complete_run();
  endtask : give_up

  task automatic edge_ready;
    int n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      give_up("bus");
    end
  endtask : edge_ready

  // one single word transfer; request held until hready is seen high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr  <= {24'h0, a};
    edge_ready();
    htrans <= 2'h0;
    hwdata <= d;
    edge_ready();
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp,
                     input string what);
    rd(a);
    chk(q, exp, what);
  endtask : rdc

  task automatic poll(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] v);
    int n = 0;
    do begin
      rd(a);
      n++;
    end while ((q & m) !== v && n < 500);
    if ((q & m) !== v) begin
      give_up("register poll");
    end
  endtask : poll

  task automatic wait_pins(input logic [1:0] m, input logic [1:0] v);
    int n = 0;
    while ((pin & m) !== v && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    if ((pin & m) !== v) begin
      give_up("pin wait");
    end
  endtask : wait_pins

  // high byte first holds the compare off, the flags read arms any set
  // flag, and the low byte write re-enables the compare and clears it
  task automatic setcmp(input int i, input logic [15:0] v);
    wr(A_CMP_HI[i], {24'h0, v[15:8]});
    rd(A_FLAGS);
    wr(A_CMP_LO[i], {24'h0, v[7:0]});
  endtask : setcmp

  // a flags read arms every set flag, the low byte accesses clear them
  task automatic clr_flags;
    rd(A_FLAGS);
    for (int i = 0; i < 2; i++) begin
      rd(A_CMP_LO[i]);
      rd(A_CAP_LO[i]);
    end
  endtask : clr_flags

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    cap_one = 1'b0;
    cap_two = 1'b0;
    ext_clk = 1'b0;
    q = 32'h0;
    n_fail = 0;
    total_checks = 0;
    repeat (20) @(posedge hclk);
    chk({30'h0, pin}, 32'h0, "pins in reset");
    hresetn <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      rdc(A_CMP_HI[i], 32'h80, "compare high at reset");
      rdc(A_CMP_LO[i], 32'h00, "compare low at reset");
    end
    wr(A_MASK, 32'h0);
    setcmp(0, 16'h0002);
    setcmp(1, 16'h0003);
    foreach (sels[k]) begin
      wr(A_CTRL_A, 32'h45);
      wr(A_CTRL_B, {24'h0, 4'hc, sels[k], 2'h1});
      wr(A_CNT, 32'h0);
      if (sels[k] == CLK_DIV8) begin
        poll(A_CNT, 32'hffff, 32'h0002);
        chk({30'h0, pin}, 32'h0, "pin at equality");
        wait_pins(2'h1, 2'h1);
        rdc(A_CNT, 32'h0003, "count at pin change");
      end
      wait_pins(2'h3, 2'h3);
      chk({30'h0, pin_oe_n}, 32'h0, "pins enabled");
      rdc(A_CMP_LO[0], 32'h02, "low byte read");
      rdc(A_FLAGS, 32'h3, "compare flags");
      chk({31'h0, timer_irq}, 32'h1, "compare irq");
      rd(A_CMP_LO[0]);
      wr(A_CMP_LO[1], 32'h03);
      rdc(A_FLAGS, 32'h0, "flags cleared");
      chk({31'h0, timer_irq}, 32'h0, "irq cleared");
      wr(A_CTRL_A, 32'h18);
      wait_pins(2'h3, 2'h0);
      rdc(A_FLAGS, 32'h0, "forced sets no flag");
      chk({31'h0, timer_irq}, 32'h0, "forced no irq");
    end
    // pins free: flag and interrupt remain, pins untouched
    wr(A_CTRL_B, 32'h04);
    wr(A_CTRL_A, 32'h45);
    wr(A_CNT, 32'h0);
    poll(A_FLAGS, 32'h3, 32'h3);
    chk({30'h0, pin_oe_n}, 32'h3, "pins released");
    chk({30'h0, pin}, 32'h0, "free pins unchanged");
    chk({31'h0, timer_irq}, 32'h1, "irq with pins free");
    wr(A_MASK, 32'h1);
    rd(A_CNT);
    chk({31'h0, timer_irq}, 32'h0, "masked irq");
    wr(A_MASK, 32'h0);
    clr_flags();
    // high byte alone must hold compare one off
    wr(A_CTRL_B, 32'hc4);
    wr(A_CMP_HI[0], 32'h0);
    wr(A_CNT, 32'h0);
    poll(A_FLAGS, 32'h2, 32'h2);
    rdc(A_FLAGS, 32'h2, "inhibited compare");
    chk({30'h0, pin}, 32'h2, "inhibited pin");
    wr(A_CMP_LO[0], 32'h02);
    wr(A_CNT, 32'h0);
    wait_pins(2'h1, 2'h1);
    wr(A_CTRL_A, 32'h18);
    wait_pins(2'h3, 2'h0);
    // single pulse: level two during the pulse, level one after it
    wr(A_CTRL_B, 32'he6);
    wr(A_CTRL_A, 32'h86);
    setcmp(0, 16'h0006);
    setcmp(1, 16'h0004);
    clr_flags();
    cap_one <= 1'b1;
    wait_pins(2'h1, 2'h1);
    wait_pins(2'h1, 2'h0);
    rdc(A_CAP_HI[0], 32'hff, "trigger capture high");
    rdc(A_CAP_LO[0], 32'hfd, "trigger capture low");
    rdc(A_FLAGS, 32'h6, "single pulse flags");
    chk({30'h0, pin}, 32'h0, "pin two idle");
    chk({31'h0, timer_irq}, 32'h1, "trigger irq");
    wr(A_CTRL_A, 32'h8f);
    rd(A_CNT);
    chk({30'h0, pin}, 32'h0, "forced ignored");
    cap_two <= 1'b1;
    poll(A_FLAGS, 32'h8, 32'h8);
    // both mode bits: modulation only, compare two restarts the period
    wr(A_CTRL_B, 32'hf4);
    wr(A_CTRL_A, 32'h83);
    setcmp(0, 16'h0002);
    setcmp(1, 16'h0005);
    clr_flags();
    wr(A_CNT, 32'h0);
    wait_pins(2'h1, 2'h1);
    wait_pins(2'h1, 2'h0);
    wait_pins(2'h1, 2'h1);
    rdc(A_FLAGS, 32'h4, "modulation flags");
    chk({31'h0, timer_irq}, 32'h1, "period irq");
    cap_one <= 1'b0;
    rd(A_CNT);
    cap_one <= 1'b1;
    rd(A_CNT);
    rdc(A_CAP_LO[0], 32'hfd, "capture one idle");
    complete_run();
  end
endmodule : tb_top
